/* logic/isa_glue_logic.sv */
// Purpose: Glue between a microcontroller local bus, an ISA Ethernet controller and memory
// Assumes: Pins are asynchronous and pass a two-flop synchroniser first
// Notes: Every output except the two spares is registered, so outputs lag pins by three clocks
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser, parameterised width
module glue_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] rstVal,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] held_q;
  logic [W-1:0] warm_q;
  logic [W-1:0] loaded_q;

  // Only the second stage reads the first; the valid mask waits two edges
  // so the zero left in the second stage by reset never reaches the logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      held_q <= '0;
      warm_q <= '0;
      loaded_q <= '0;
    end else begin
      meta_q <= d;
      held_q <= meta_q;
      warm_q <= '1;
      loaded_q <= warm_q;
    end
  end

  // Until data has passed, present the inactive level given by the parent
  assign q = (loaded_q & held_q) | (~loaded_q & rstVal);
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top glue block
module isa_glue_logic (
  input wire logic clk,
  input wire logic rstn,
  input wire glue_pkg::glueIn_t busIn,
  input wire glue_pkg::flashIn_t flashIn,
  input wire logic midrangeMemSelect0N,
  input wire logic [glue_pkg::PIO_W-1:0] programmableIo,
  input wire logic [glue_pkg::ETH_LEDS-1:0] ethStatusOut,
  output glue_pkg::glueOut_t glueOut,
  output logic [glue_pkg::ACT_LEDS-1:0] activityLed,
  output logic [glue_pkg::ETH_LEDS-1:0] ethStatusLed
);
  import glue_pkg::*;

  localparam int BUS_W = $bits(glueIn_t);
  localparam int FL_W = $bits(flashIn_t);
  localparam int MISC_W = PIO_W + ETH_LEDS;

  glueIn_t busS;
  flashIn_t flashS;
  logic [MISC_W-1:0] miscS;
  logic [PIO_W-1:0] pioS;
  logic [ETH_LEDS-1:0] ethS;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers; strobes and selects rest inactive until data arrives
  glue_sync2 #(.W(BUS_W)) syncBus (
    .clk(clk),
    .rstn(rstn),
    .rstVal(8'hFF),
    .d(busIn),
    .q(busS)
  );

  glue_sync2 #(.W(FL_W)) syncFlash (
    .clk(clk),
    .rstn(rstn),
    .rstVal(3'h6),
    .d(flashIn),
    .q(flashS)
  );

  glue_sync2 #(.W(MISC_W)) syncMisc (
    .clk(clk),
    .rstn(rstn),
    .rstVal(20'h00000),
    .d({programmableIo, ethStatusOut}),
    .q(miscS)
  );

  // Mid-range select has no effect on any output
  assign pioS = miscS[MISC_W-1:ETH_LEDS];
  assign ethS = miscS[ETH_LEDS-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Byte high enable decode
  wire logic readCyc = ~busS.iorN;
  wire logic writeCyc = ~busS.iowN;
  wire logic strobeOn = readCyc | writeCyc;
  wire logic wordEvenWr = writeCyc & ~busS.bheN & ~busS.addr0;
  wire logic byteOddWr = writeCyc & ~busS.bheN & busS.addr0;
  wire logic upperLane = wordEvenWr | byteOddWr;
  wire logic sbheWant = readCyc | upperLane;

  sbheState_t state_q;
  sbheState_t state_d;
  logic [CNT_W-1:0] holdCnt_q;
  logic [CNT_W-1:0] holdCnt_d;
  logic sbheN_q;
  logic sbheN_d;

  // One-shot: reload at strobe end, hold enable until count expires
  always_comb begin
    state_d = state_q;
    holdCnt_d = holdCnt_q;
    sbheN_d = sbheN_q;
    case (state_q)
      S_IDLE: begin
        sbheN_d = RST_INACTIVE_N;
        if (strobeOn) begin
          state_d = S_CYCLE;
          sbheN_d = ~sbheWant;
        end
      end
      S_CYCLE: begin
        if (strobeOn) begin
          sbheN_d = ~sbheWant;
        end else begin
          state_d = S_HOLD;
          holdCnt_d = SBHE_HOLD_CYC;
        end
      end
      S_HOLD: begin
        if (strobeOn) begin
          state_d = S_CYCLE;
          sbheN_d = ~sbheWant;
        end else if (holdCnt_q <= CNT_ONE) begin
          state_d = S_IDLE;
          holdCnt_d = CNT_ZERO;
          sbheN_d = RST_INACTIVE_N;
        end else begin
          holdCnt_d = holdCnt_q - CNT_ONE;
        end
      end
      default: begin
        state_d = S_IDLE;
        holdCnt_d = CNT_ZERO;
        sbheN_d = RST_INACTIVE_N;
      end
    endcase
  end

  // One-shot registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      holdCnt_q <= CNT_ZERO;
      sbheN_q <= RST_INACTIVE_N;
    end else begin
      state_q <= state_d;
      holdCnt_q <= holdCnt_d;
      sbheN_q <= sbheN_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // SRAM write strobe: merged byte strobes, stretched to the least width
  wire logic byteWrOn = ~busS.writeHighByteStrobeN | ~busS.writeLowByteStrobeN;
  logic byteWrOn_q;
  logic [CNT_W-1:0] wrCnt_q;
  wire logic wrStart = byteWrOn & ~byteWrOn_q;
  wire logic [CNT_W-1:0] wrCnt_d = wrStart ? SRAM_WR_MIN_CYC - CNT_ONE :
    (wrCnt_q != CNT_ZERO) ? wrCnt_q - CNT_ONE : CNT_ZERO;
  wire logic sramWrNext = ~(byteWrOn | (wrCnt_q != CNT_ZERO));

  // RAM select stays on while the controller masters the bus
  wire logic ramSelNext = busS.lowerMemSelectN & busS.masterN;

  // Flash enable source select; unselected source never reaches the flash
  wire logic flashNext = flashS.flashSourceSelector ?
    flashS.extFlashSelectN : flashS.upperMemSelectN;

  // Indicator routing
  wire logic [ACT_LEDS-1:0] actNext = {pioS[ACT_BIT7], pioS[ACT_BIT6], pioS[ACT_BIT5],
    pioS[ACT_BIT4], pioS[ACT_BIT3], pioS[ACT_BIT2], pioS[ACT_BIT1], pioS[ACT_BIT0]};
  wire logic [ETH_LEDS-1:0] ethNext = {ethS[0], ethS[1], ethS[2], ethS[3]};

  logic ramSel_q;
  logic sramWr_q;
  logic flashCe_q;
  logic [ACT_LEDS-1:0] act_q;
  logic [ETH_LEDS-1:0] eth_q;

  // Output and stretch registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byteWrOn_q <= 1'h0;
      wrCnt_q <= CNT_ZERO;
      ramSel_q <= RST_INACTIVE_N;
      sramWr_q <= RST_INACTIVE_N;
      flashCe_q <= RST_INACTIVE_N;
      act_q <= RST_ACT;
      eth_q <= RST_ETH;
    end else begin
      byteWrOn_q <= byteWrOn;
      wrCnt_q <= wrCnt_d;
      ramSel_q <= ramSelNext;
      sramWr_q <= sramWrNext;
      flashCe_q <= flashNext;
      act_q <= actNext;
      eth_q <= ethNext;
    end
  end

  // Six outputs, two spare held inactive
  assign glueOut = '{sbheN: sbheN_q, ramSelectOutN: ramSel_q, sramWriteN: sramWr_q,
    flashCeN: flashCe_q, spare0: RST_INACTIVE_N, spare1: RST_INACTIVE_N};
  assign activityLed = act_q;
  assign ethStatusLed = eth_q;

endmodule

`default_nettype wire

/* logic/glue_pkg.sv */
// Purpose: Shared constants and carrier types for the bus glue block
// Assumes: Single 25 MHz clock, all pin inputs asynchronous to it
// Notes: Times are kept in ns and turned into cycle counts here
package glue_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SBHE_HOLD_NS = 5;
  localparam int SRAM_WR_MIN_NS = 50;
  // Least times round up to whole cycles, never below one
  localparam int SBHE_HOLD_CYC_I = (SBHE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRAM_WR_MIN_CYC_I = (SRAM_WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] SBHE_HOLD_CYC = (SBHE_HOLD_CYC_I < 1) ? CNT_W'(1) :
    CNT_W'(SBHE_HOLD_CYC_I);
  localparam logic [CNT_W-1:0] SRAM_WR_MIN_CYC = (SRAM_WR_MIN_CYC_I < 1) ? CNT_W'(1) :
    CNT_W'(SRAM_WR_MIN_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

  // Indicator positions within the programmable I/O word
  localparam int PIO_W = 16;
  localparam int ACT_LEDS = 8;
  localparam int ACT_BIT7 = 15;
  localparam int ACT_BIT6 = 14;
  localparam int ACT_BIT5 = 5;
  localparam int ACT_BIT4 = 4;
  localparam int ACT_BIT3 = 3;
  localparam int ACT_BIT2 = 2;
  localparam int ACT_BIT1 = 1;
  localparam int ACT_BIT0 = 0;
  localparam int ETH_LEDS = 4;

  // Reset values of the outputs (all active-low lines inactive)
  localparam logic RST_INACTIVE_N = 1'h1;
  localparam logic [ACT_LEDS-1:0] RST_ACT = 8'h00;
  localparam logic [ETH_LEDS-1:0] RST_ETH = 4'h0;

  // Eight glue inputs from the processor and controller side
  typedef struct packed {
    logic iorN;       // I/O read strobe
    logic iowN;       // I/O write strobe
    logic bheN;       // Processor byte high enable
    logic addr0;      // Address bit 0
    logic writeHighByteStrobeN;
    logic writeLowByteStrobeN;
    logic lowerMemSelectN;
    logic masterN;    // Ethernet controller owns the bus
  } glueIn_t;

  // Flash chip-enable sources
  typedef struct packed {
    logic upperMemSelectN;
    logic extFlashSelectN;
    logic flashSourceSelector;  // 1 = expansion connector drives flash
  } flashIn_t;

  // Six glue outputs
  typedef struct packed {
    logic sbheN;
    logic ramSelectOutN;
    logic sramWriteN;
    logic flashCeN;
    logic spare0;
    logic spare1;
  } glueOut_t;

  // One-shot states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CYCLE = 3'b010,
    S_HOLD = 3'b100
  } sbheState_t;

endpackage

/* bench/eth_status_model.sv */
// Purpose: Far-side model of the Ethernet controller status outputs
// Assumes: Status lines are plain levels
// Notes: Output 3 is inverted by the controller's setup
`timescale 1ns/1ps
`default_nettype none
module eth_status_model (
  input wire logic link,
  input wire logic rxAct,
  input wire logic txAct,
  input wire logic polWrong,
  output logic [3:0] ethStatusOut
);
  // Link, receive, transmit, inverted polarity on outputs 0 to 3
  assign ethStatusOut = {~polWrong, txAct, rxAct, link};
endmodule
`default_nettype wire

/* bench/isa_glue_logic_assertions.sv */
// Purpose: Port checker for the bus glue block
// Assumes: Outputs follow pins three clocks later
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module isa_glue_logic_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire glue_pkg::glueIn_t busIn,
  input wire glue_pkg::flashIn_t flashIn,
  input wire logic [glue_pkg::PIO_W-1:0] programmableIo,
  input wire logic [glue_pkg::ETH_LEDS-1:0] ethStatusOut,
  input wire glue_pkg::glueOut_t glueOut,
  input wire logic [glue_pkg::ACT_LEDS-1:0] activityLed,
  input wire logic [glue_pkg::ETH_LEDS-1:0] ethStatusLed
);
  import glue_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Read strobe ends cleanly, then one hold cycle
  sequence rdEnd;
    (!busIn.iorN && busIn.iowN) ##1 (busIn.iorN && busIn.iowN) [*3];
  endsequence
  sequence holdThenOff;
    !glueOut.sbheN ##1 glueOut.sbheN;
  endsequence
  // Byte high enable
  a_read_sbhe: assert property ($past(!busIn.iorN, 3) |-> !glueOut.sbheN)
    else $error("enable missing on read");
  a_write_upper: assert property ($past(!busIn.iowN && !busIn.bheN, 3) |-> !glueOut.sbheN)
    else $error("enable missing on upper write");
  a_idle_sbhe: assert property ($past(busIn.iorN && (busIn.iowN || busIn.bheN), 3) &&
    $past(busIn.iorN && (busIn.iowN || busIn.bheN), 4) |-> glueOut.sbheN)
    else $error("enable asserted without cause");
  a_sbhe_hold: assert property (rdEnd |=> holdThenOff)
    else $error("enable hold wrong");
  // Memory selects and strobes
  a_ram_or: assert property (glueOut.ramSelectOutN ==
    $past(busIn.lowerMemSelectN & busIn.masterN, 3))
    else $error("ram select wrong");
  a_sram_merge: assert property ($past(!busIn.writeHighByteStrobeN ||
    !busIn.writeLowByteStrobeN, 3) |-> !glueOut.sramWriteN)
    else $error("sram strobe missing");
  a_sram_width: assert property ($fell(glueOut.sramWriteN) |=> !glueOut.sramWriteN)
    else $error("sram strobe too short");
  a_flash_mux: assert property (glueOut.flashCeN == $past(flashIn.flashSourceSelector ?
    flashIn.extFlashSelectN : flashIn.upperMemSelectN, 3))
    else $error("flash enable wrong");
  // Indicators
  a_act_leds: assert property (activityLed == $past({programmableIo[15:14],
    programmableIo[5:0]}, 3))
    else $error("activity led wrong");
  a_eth_rev: assert property (ethStatusLed == $past({ethStatusOut[0], ethStatusOut[1],
    ethStatusOut[2], ethStatusOut[3]}, 3))
    else $error("status led order wrong");
endmodule
bind isa_glue_logic isa_glue_logic_assertions chk (
  .clk(clk),
  .rstn(rstn),
  .busIn(busIn),
  .flashIn(flashIn),
  .programmableIo(programmableIo),
  .ethStatusOut(ethStatusOut),
  .glueOut(glueOut),
  .activityLed(activityLed),
  .ethStatusLed(ethStatusLed)
);
`default_nettype wire

/* bench/isa_glue_logic_bench.sv */
// Purpose: Self-checking bench for the bus glue block
// Assumes: Outputs settle three edges after a pin change
// Notes: Fixed waits follow the three-clock latency
`timescale 1ns/1ps
`default_nettype none
module isa_glue_logic_bench;
  import glue_pkg::*;
  logic clk;
  logic rstn;
  glueIn_t busIn;
  flashIn_t flashIn;
  logic midSelN;
  logic [15:0] programmable_io;
  logic link, rxAct, txAct, polWrong;
  logic [3:0] ethStatusOut;
  glueOut_t glueOut;
  logic [7:0] activityLed;
  logic [3:0] ethStatusLed;
  int failures;
  int compares;
  eth_status_model eth (.link(link), .rxAct(rxAct), .txAct(txAct), .polWrong(polWrong),
    .ethStatusOut(ethStatusOut));
  isa_glue_logic dut (.clk(clk), .rstn(rstn), .busIn(busIn), .flashIn(flashIn),
    .midrangeMemSelect0N(midSelN), .programmableIo(programmable_io), .ethStatusOut(ethStatusOut),
    .glueOut(glueOut), .activityLed(activityLed), .ethStatusLed(ethStatusLed));
  ////////////////////////////////////////
  // Clock, verdict and shared helpers
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task results;
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////
  // Scenarios
  task t_read;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      busIn.iorN <= 1'h0;
      busIn.bheN <= i[0];
      settle(4);
      check(8'(glueOut.sbheN), 8'h0);
      @(posedge clk);
      busIn.iorN <= 1'h1;
      settle(3);
      check(8'(glueOut.sbheN), 8'h0);
      settle(1);
      check(8'(glueOut.sbheN), 8'h1);
    end
  endtask
  task t_write;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      busIn.iowN <= 1'h0;
      busIn.bheN <= i[1];
      busIn.addr0 <= i[0];
      settle(4);
      check(8'(glueOut.sbheN), 8'(i[1]));
      @(posedge clk);
      busIn.iowN <= 1'h1;
      settle(6);
    end
  endtask
  task t_ram;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      busIn.masterN <= i[0];
      busIn.lowerMemSelectN <= i[1];
      midSelN <= i[2];
      settle(4);
      check(8'(glueOut.ramSelectOutN), 8'(i[1] & i[0]));
    end
  endtask
  task t_flash;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      flashIn <= 3'(i);
      settle(4);
      check(8'(glueOut.flashCeN), 8'(i[0] ? i[1] : i[2]));
    end
  endtask
  task t_sram;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      busIn[2+i] <= 1'h0;
      @(posedge clk);
      busIn[2+i] <= 1'h1;
      settle(3);
      check(8'(glueOut.sramWriteN), 8'h0);
      settle(4);
      check(8'(glueOut.sramWriteN), 8'h1);
    end
  endtask
  task t_leds;
    logic [15:0] p;
    for (int i = 0; i < 16; i++) begin
      p = 16'hA5C3 ^ (16'h0001 << i);
      @(posedge clk);
      programmable_io <= p;
      {polWrong, txAct, rxAct, link} <= 4'(i);
      settle(4);
      check(activityLed, {p[15:14], p[5:0]});
      check(8'(ethStatusLed), 8'({i[0], i[1], i[2], ~i[3]}));
    end
  endtask
  ////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    rstn = 1'h0;
    busIn = 8'hFF;
    flashIn = 3'h6;
    midSelN = 1'h1;
    programmable_io = 16'h0000;
    {polWrong, txAct, rxAct, link} = 4'h8;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    #1;
    check(8'(glueOut), 8'h3F);
    check(activityLed, 8'h00);
    t_read();
    t_write();
    t_ram();
    t_flash();
    t_sram();
    t_leds();
    results();
  end
  initial begin
    #400000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
